// file: verilog/adcoi_config_top.v
// output interface configuration bank behind the serial register port
`include "adcoi_consts.vh"

module adcoi_config_top (
    input  wire        sys_clk_i,              // system clock, 10 mhz
    input  wire        reset_n_i,              // async reset, active low
    input  wire        spi_sen_n_i,            // serial enable pin, active low
    input  wire        spi_sclk_i,             // serial clock pin
    input  wire        spi_sdata_i,            // serial data in pin
    output wire        spi_sdout_o,            // serial data out
    output wire        spi_sdout_oe_o,         // serial data out enable
    input  wire        pin_control_override_i, // override of control pins
    input  wire        sample_strobe_i,        // one pulse per sample
    input  wire        double_mode_i,          // double-pattern mode active
    input  wire [15:0] pattern_one_i,          // first user pattern
    input  wire [7:0]  pattern_two_high_i,     // second pattern high byte
    output wire [15:0] second_user_pattern_o,  // full second pattern
    output wire [15:0] test_pattern_o,         // pattern for current sample
    output wire        shared_clk_dbl_o,       // shared clock pair double drive
    output wire        per_channel_clk_dbl_o,  // per-channel clock double drive
    output wire        data_dbl_o,             // data buffers double drive
    output wire        frame_clk_dbl_o,        // frame clock double drive
    output wire        chan_a_output_off_o,    // channel a buffers high-z
    output wire        chan_b_output_off_o,    // channel b buffers high-z
    output wire        output_rate_mode_o,     // 0 qdr, 1 ddr
    output wire [4:0]  ddr_clk_delay_o,        // effective delay code
    output wire        ddr_delay_illegal_o     // programmed code not listed
);

    // pins are oversampled, so each
    // sclk phase needs four clocks
    // frame: read flag, address, data
    // a write commits at the last bit
    // an aborted frame changes nothing
    // controls are re-registered: one
    // cycle of lag, but no glitches
    // while a register is rewritten

    // serial port state codes
    localparam ST_IDLE  = 1'b0;
    localparam ST_SHIFT = 1'b1;
    // reset level of each sync stage;
    // enable idles high, the rest low
    localparam [2:0] SYNC_INIT = `ADCOI_SYNC_RESET;

    // legal delay code check; used for both effective code and flag
    function legal_code;
        input [4:0] code;
        begin
            case (code)
                `ADCOI_DLY_M180, `ADCOI_DLY_M100, `ADCOI_DLY_ZERO,
                `ADCOI_DLY_P120, `ADCOI_DLY_P230, `ADCOI_DLY_P320,
                `ADCOI_DLY_P400, `ADCOI_DLY_P500: legal_code = 1'b1;
                default:                          legal_code = 1'b0;
            endcase
        end
    endfunction

    // --- synchronisers for the serial pins ---
    // pins are in another clock domain;
    // two flops each keep metastability
    // out of the frame engine
    wire [2:0]  pin_raw;                   // sen, sclk, sdata as sampled
    reg  [2:0]  sync1_reg;                 // first stage, read only by second
    reg  [2:0]  sync2_reg;                 // second stage, safe to use
    reg         sclk_prev_reg;             // sclk history for edge detect

    assign pin_raw = {spi_sdata_i, spi_sclk_i, spi_sen_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            // two flops per pin; sen idles high so its stages reset to one
            always @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    sync1_reg[gi] <= SYNC_INIT[gi];
                    sync2_reg[gi] <= SYNC_INIT[gi];
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    wire sen_n_s   = sync2_reg[0];         // enable, active low
    wire sclk_s    = sync2_reg[1];         // serial clock
    wire sdata_s   = sync2_reg[2];         // serial data
    wire sclk_rise = sclk_s & ~sclk_prev_reg;
    wire sclk_fall = ~sclk_s & sclk_prev_reg;

    // --- register storage ---
    reg  [7:0]  pat2_lo_reg;               // second pattern low byte
    reg  [7:0]  drive_reg;                 // drive strength and disables
    reg  [7:0]  rate_reg;                  // output rate select
    reg  [7:0]  delay_reg;                 // ddr clock delay field
    reg  [7:0]  clk_en_reg;                // clock strength enable

    // --- serial engine state ---
    reg         state_reg;                 // idle or shifting
    reg  [4:0]  bit_cnt_reg;               // bits taken in this frame
    reg  [15:0] shift_in_reg;              // incoming frame bits
    reg  [7:0]  rd_shift_reg;              // read data being returned
    reg         is_read_reg;               // frame is a read
    reg         sdout_reg;                 // serial out bit
    reg         sdout_oe_reg;              // serial out drive enable

    wire [15:0] word_now = {shift_in_reg[14:0], sdata_s}; // frame incl. this bit
    wire [6:0]  addr_now = word_now[6:0];  // address once eight bits are in
    wire [6:0]  addr_wr  = word_now[14:8]; // address at frame end
    wire [7:0]  data_wr  = word_now[7:0];  // write data at frame end

    // address is whole after bit eight;
    // a read returns the value then
    // read mux; write-only zero bits read back as zero
    reg  [7:0]  rd_value;
    always @* begin
        case (addr_now)
            `ADCOI_ADDR_PAT2_LO:   rd_value = pat2_lo_reg;
            `ADCOI_ADDR_DRIVE:     rd_value = drive_reg;
            `ADCOI_ADDR_RATE:      rd_value = rate_reg;
            `ADCOI_ADDR_DDR_DELAY: rd_value = delay_reg;
            `ADCOI_ADDR_CLK_EN:    rd_value = clk_en_reg;
            default:               rd_value = `ADCOI_RESET_BYTE; // unmapped reads 0
        endcase
    end

    // read data leaves on the fall so
    // it settles a full phase before
    // the host samples it at the rise
    // bits past sixteen are ignored, so
    // extra clocks start no new access
    // serial frame engine: sample on sclk rise, shift out on sclk fall
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg     <= ST_IDLE;
            bit_cnt_reg   <= 5'h00;
            shift_in_reg  <= `ADCOI_RESET_WORD;
            rd_shift_reg  <= `ADCOI_RESET_BYTE;
            is_read_reg   <= 1'b0;
            sdout_reg     <= 1'b0;
            sdout_oe_reg  <= 1'b0;
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
            case (state_reg)
                ST_IDLE: begin
                    sdout_oe_reg <= 1'b0;
                    bit_cnt_reg  <= 5'h00;
                    is_read_reg  <= 1'b0;
                    // a frame starts when enable falls
                    if (!sen_n_s) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (sen_n_s) begin
                        // enable raised: frame done or aborted, nothing pending
                        state_reg    <= ST_IDLE;
                        sdout_oe_reg <= 1'b0;
                    end else if (sclk_rise && bit_cnt_reg <= `ADCOI_FRAME_LAST) begin
                        shift_in_reg <= word_now;
                        bit_cnt_reg  <= bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg == `ADCOI_ADDR_LAST) begin
                            // address complete: latch read data now
                            is_read_reg  <= word_now[7];
                            rd_shift_reg <= rd_value;
                        end
                    end else if (sclk_fall && is_read_reg &&
                                 bit_cnt_reg >= `ADCOI_DATA_FIRST &&
                                 bit_cnt_reg <= `ADCOI_FRAME_LAST) begin
                        // drive next bit so it is stable at the following rise
                        sdout_reg    <= rd_shift_reg[7];
                        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
                        sdout_oe_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // frame end condition for a write
    wire wr_fire = (state_reg == ST_SHIFT) && !sen_n_s && sclk_rise &&
                   (bit_cnt_reg == `ADCOI_FRAME_LAST) && !word_now[15];

    // only the sixteenth rise commits;
    // unmapped addresses are dropped
    // register writes; reserved bits are forced to zero whatever the host sends
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pat2_lo_reg <= `ADCOI_RESET_BYTE;
            drive_reg   <= `ADCOI_RESET_BYTE;
            rate_reg    <= `ADCOI_RESET_BYTE;
            delay_reg   <= `ADCOI_RESET_BYTE;
            clk_en_reg  <= `ADCOI_RESET_BYTE;
        end else if (wr_fire) begin
            case (addr_wr)
                `ADCOI_ADDR_PAT2_LO:   pat2_lo_reg <= data_wr;
                `ADCOI_ADDR_DRIVE:     drive_reg   <= data_wr & `ADCOI_MASK_DRIVE;
                `ADCOI_ADDR_RATE:      rate_reg    <= data_wr & `ADCOI_MASK_RATE;
                `ADCOI_ADDR_DDR_DELAY: delay_reg   <= data_wr & `ADCOI_MASK_DELAY;
                `ADCOI_ADDR_CLK_EN:    clk_en_reg  <= data_wr & `ADCOI_MASK_CLK_EN;
                default:               pat2_lo_reg <= pat2_lo_reg; // unmapped: ignored
            endcase
        end
    end

    // clock strength needs the enable
    // in 17h; ddr steers it to the
    // shared pair, qdr to per-channel
    // an unlisted delay code has no
    // defined timing, so it is not used
    // --- derived control outputs, all registered ---
    wire        ddr_mode   = rate_reg[`ADCOI_RATE_BIT];
    wire        clk_dbl_ok = drive_reg[`ADCOI_CLK_DBL_BIT] &
                             clk_en_reg[`ADCOI_CLK_EN_BIT];
    wire [4:0]  code_prog  = delay_reg[`ADCOI_DELAY_MSB:`ADCOI_DELAY_LSB];

    reg         shared_clk_dbl_reg;    // shared clock pair strength
    reg         per_clk_dbl_reg;       // per-channel clock pairs strength
    reg         data_dbl_reg;          // data buffer strength
    reg         frame_dbl_reg;         // frame clock strength
    reg         cha_off_reg;           // channel a tri-state
    reg         chb_off_reg;           // channel b tri-state
    reg         rate_mode_reg;         // rate mode copy
    reg  [4:0]  delay_eff_reg;         // delay code in force
    reg         delay_bad_reg;         // unlisted code programmed

    // one cycle from the register to the buffer controls
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shared_clk_dbl_reg <= 1'b0;
            per_clk_dbl_reg    <= 1'b0;
            data_dbl_reg       <= 1'b0;
            frame_dbl_reg      <= 1'b0;
            cha_off_reg        <= 1'b0;
            chb_off_reg        <= 1'b0;
            rate_mode_reg      <= 1'b0;
            delay_eff_reg      <= `ADCOI_RESET_CODE;
            delay_bad_reg      <= 1'b0;
        end else begin
            // clock strength lands on whichever clock pins the pinout uses
            shared_clk_dbl_reg <= clk_dbl_ok & ddr_mode;
            per_clk_dbl_reg    <= clk_dbl_ok & ~ddr_mode;
            data_dbl_reg       <= drive_reg[`ADCOI_DATA_DBL_BIT];
            // frame clock pins exist only in the qdr pinout
            frame_dbl_reg      <= drive_reg[`ADCOI_DATA_DBL_BIT] & ~ddr_mode;
            cha_off_reg        <= drive_reg[`ADCOI_CHA_OFF_BIT];
            chb_off_reg        <= drive_reg[`ADCOI_CHB_OFF_BIT];
            rate_mode_reg      <= ddr_mode;
            // an unlisted code falls back to the default clock position
            if (pin_control_override_i && legal_code(code_prog)) begin
                delay_eff_reg <= code_prog;
            end else begin
                delay_eff_reg <= `ADCOI_RESET_CODE;
            end
            delay_bad_reg      <= ~legal_code(code_prog);
        end
    end

    // high byte from the pattern_two_high_i input,
    // low byte from 13h
    // second pattern is shared by both channels
    reg  [15:0] pat2_full_reg;
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pat2_full_reg <= `ADCOI_RESET_WORD;
        end else begin
            pat2_full_reg <= {pattern_two_high_i, pat2_lo_reg};
        end
    end

    // pattern source for double-pattern mode
    // kept apart so other test patterns
    // can share the sample phase
    adcoi_pattern_alt u_pattern (
        .sys_clk_i       (sys_clk_i),
        .reset_n_i       (reset_n_i),
        .sample_strobe_i (sample_strobe_i),
        .double_mode_i   (double_mode_i),
        .pattern_one_i   (pattern_one_i),
        .pattern_two_i   (pat2_full_reg),
        .pattern_o       (test_pattern_o)
    );

    // every output is a flop; reserved
    // bits read zero, being masked on write
    // sdout enable drops once enable
    // is seen high again
    assign spi_sdout_o           = sdout_reg;
    assign spi_sdout_oe_o        = sdout_oe_reg;
    assign second_user_pattern_o = pat2_full_reg;
    assign shared_clk_dbl_o      = shared_clk_dbl_reg;
    assign per_channel_clk_dbl_o = per_clk_dbl_reg;
    assign data_dbl_o            = data_dbl_reg;
    assign frame_clk_dbl_o       = frame_dbl_reg;
    assign chan_a_output_off_o   = cha_off_reg;
    assign chan_b_output_off_o   = chb_off_reg;
    assign output_rate_mode_o    = rate_mode_reg;
    assign ddr_clk_delay_o       = delay_eff_reg;
    assign ddr_delay_illegal_o   = delay_bad_reg;

endmodule

// file: verilog/adcoi_consts.vh
// constants for the adc output interface configuration bank
// How it works
// - register 13h holds shared pattern two low byte
// - clock drive double bit doubles clock buffers
// - clock double honoured only with enable set
// - ddr drives shared clock, qdr per-channel clocks
// - data double bit doubles data buffers, and frame buffers in qdr only
// - channel a off bit tri-states channel a
// - channel b off bit tri-states channel b
// - rate bit: zero qdr default, one ddr
// - delay code applies only under pin override
// - only eight listed delay codes are legal
// - register 17h bit 7 enables clock strength
// - double pattern alternates patterns each sample
`ifndef ADCOI_CONSTS_VH
`define ADCOI_CONSTS_VH

// register offsets on the serial port
`define ADCOI_ADDR_PAT2_LO     7'h13
`define ADCOI_ADDR_DRIVE       7'h14
`define ADCOI_ADDR_RATE        7'h15
`define ADCOI_ADDR_DDR_DELAY   7'h16
`define ADCOI_ADDR_CLK_EN      7'h17

// field positions
`define ADCOI_CLK_DBL_BIT      3
`define ADCOI_DATA_DBL_BIT     2
`define ADCOI_CHA_OFF_BIT      1
`define ADCOI_CHB_OFF_BIT      0
`define ADCOI_RATE_BIT         0
`define ADCOI_DELAY_MSB        5
`define ADCOI_DELAY_LSB        1
`define ADCOI_CLK_EN_BIT       7

// writable masks; all other bits are write-only zeros and read as zero
`define ADCOI_MASK_DRIVE       8'h0F
`define ADCOI_MASK_RATE        8'h01
`define ADCOI_MASK_DELAY       8'h3E
`define ADCOI_MASK_CLK_EN      8'h80

// reset values
`define ADCOI_RESET_BYTE       8'h00
`define ADCOI_RESET_CODE       5'h00
`define ADCOI_RESET_WORD       16'h0000

// legal ddr clock delay codes
`define ADCOI_DLY_M180         5'h05
`define ADCOI_DLY_M100         5'h07
`define ADCOI_DLY_ZERO         5'h00
`define ADCOI_DLY_P120         5'h0D
`define ADCOI_DLY_P230         5'h0E
`define ADCOI_DLY_P320         5'h0B
`define ADCOI_DLY_P400         5'h14
`define ADCOI_DLY_P500         5'h10

// serial frame layout: r/w flag, 7 address bits, 8 data bits
`define ADCOI_FRAME_LAST       5'h0F
`define ADCOI_ADDR_LAST        5'h07
`define ADCOI_DATA_FIRST       5'h08
`define ADCOI_SYNC_RESET       3'h1

`endif

// file: verilog/adcoi_pattern_alt.v
// user pattern source that alternates two patterns in double-pattern mode
`include "adcoi_consts.vh"

module adcoi_pattern_alt (
    input  wire        sys_clk_i,        // system clock
    input  wire        reset_n_i,        // async reset, active low
    input  wire        sample_strobe_i,  // one pulse per output sample
    input  wire        double_mode_i,    // double-pattern test mode selected
    input  wire [15:0] pattern_one_i,    // first user pattern
    input  wire [15:0] pattern_two_i,    // second user pattern
    output wire [15:0] pattern_o         // pattern for the current sample
);

    reg        pick_two_reg;             // next sample takes pattern two
    reg [15:0] pattern_reg;              // registered pattern word

    assign pattern_o = pattern_reg;

    // alternate on each sample; outside double mode stay on pattern one
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pick_two_reg <= 1'b0;
            pattern_reg  <= `ADCOI_RESET_WORD;
        end else if (sample_strobe_i) begin
            if (double_mode_i) begin
                // the phase restarts at pattern one after any sample taken outside the mode
                pattern_reg  <= pick_two_reg ? pattern_two_i : pattern_one_i;
                pick_two_reg <= ~pick_two_reg;
            end else begin
                pattern_reg  <= pattern_one_i;
                pick_two_reg <= 1'b0;
            end
        end
    end

endmodule

// file: verification/adcoi_config_properties.sv
// concurrent checks on the configuration bank's output ports
module adcoi_config_checker (
    input wire logic        sys_clk_i,              // system clock
    input wire logic        reset_n_i,              // async reset, active low
    input wire logic        pin_control_override_i, // delay code override
    input wire logic        sample_strobe_i,        // one pulse per sample
    input wire logic [7:0]  pattern_two_high_i,     // second pattern high byte
    input wire logic [15:0] second_user_pattern_o,  // full second pattern
    input wire logic [15:0] test_pattern_o,         // pattern for current sample
    input wire logic        shared_clk_dbl_o,       // shared clock double drive
    input wire logic        per_channel_clk_dbl_o,  // per-channel clock double drive
    input wire logic        data_dbl_o,             // data double drive
    input wire logic        frame_clk_dbl_o,        // frame clock double drive
    input wire logic        output_rate_mode_o,     // 0 qdr, 1 ddr
    input wire logic [4:0]  ddr_clk_delay_o,        // effective delay code
    input wire logic        ddr_delay_illegal_o     // programmed code not listed
);
    // one clock domain, so clock and disable are given once here
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // clock strength lands on at most one pair, chosen by the pinout
    chk_clk_pair_excl: assert property (!(shared_clk_dbl_o && per_channel_clk_dbl_o))
        else $error("both clock pair drives doubled");
    chk_shared_ddr: assert property (shared_clk_dbl_o |-> output_rate_mode_o)
        else $error("shared clock doubled outside ddr");
    chk_perchan_qdr: assert property (per_channel_clk_dbl_o |-> !output_rate_mode_o)
        else $error("per-channel clock doubled outside qdr");
    // frame buffers follow data strength, but exist only in qdr
    chk_frame_qdr: assert property (frame_clk_dbl_o |-> data_dbl_o && !output_rate_mode_o)
        else $error("frame clock doubled without cause");
    chk_frame_follow: assert property (data_dbl_o && !output_rate_mode_o |-> frame_clk_dbl_o)
        else $error("frame clock not doubled with data in qdr");
    // the effective delay never leaves the listed set
    chk_delay_legal: assert property (
        ddr_clk_delay_o inside {5'h05, 5'h07, 5'h00, 5'h0d, 5'h0e, 5'h0b, 5'h14, 5'h10})
        else $error("effective delay code not listed");
    chk_illegal_zero: assert property (ddr_delay_illegal_o |-> ddr_clk_delay_o == 5'h00)
        else $error("illegal code not forced to default");
    chk_delay_override: assert property (
        !$past(pin_control_override_i) |-> ddr_clk_delay_o == 5'h00)
        else $error("delay applied without override");
    // first edge after reset still sees reset values, hence the guard
    chk_pat_high: assert property (
        $past(reset_n_i) |-> second_user_pattern_o[15:8] == $past(pattern_two_high_i))
        else $error("second pattern high byte wrong");
    chk_pat_hold: assert property (
        $past(reset_n_i) && !$past(sample_strobe_i) |-> $stable(test_pattern_o))
        else $error("test pattern moved without strobe");

    cov_shared: cover property (shared_clk_dbl_o);
    cov_perchan: cover property (per_channel_clk_dbl_o);
    cov_delay: cover property (ddr_clk_delay_o == 5'h10);
endmodule

bind adcoi_config_top adcoi_config_checker i_adcoi_config_checker (
    .sys_clk_i, .reset_n_i, .pin_control_override_i, .sample_strobe_i,
    .pattern_two_high_i, .second_user_pattern_o, .test_pattern_o, .shared_clk_dbl_o,
    .per_channel_clk_dbl_o, .data_dbl_o, .frame_clk_dbl_o, .output_rate_mode_o,
    .ddr_clk_delay_o, .ddr_delay_illegal_o
);

// file: verification/adcoi_host_model.sv
// host controller model driving the serial register port
module adcoi_host_model (
    input  wire logic sys_clk_i, // system clock
    output logic      sen_n_o,   // serial enable, active low
    output logic      sclk_o,    // serial clock, idle low
    output logic      sdata_o,   // serial data to the device
    input  wire logic sdout_i    // serial data from the device
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle: not selected, clock low
    initial begin
        sen_n_o = 1'b1;
        sclk_o  = 1'b0;
        sdata_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // one 16-bit frame msb first; high phases of 5 clocks and low phases of 6 keep the 4-clock minimum
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat,
                        output logic [7:0] rdat);
        logic [15:0] word;
        word = {rd, addr, wdat};
        rdat = 8'h00;
        tick(1);
        sen_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            // data moves a little after the fall, never next to a rise
            tick(2);
            sdata_o <= word[i];
            tick(4);
            sclk_o <= 1'b1;
            if (i < 8) rdat = {rdat[6:0], sdout_i};
            tick(5);
            sclk_o <= 1'b0;
        end
        tick(2);
        sen_n_o <= 1'b1;
        // released line shows the inverse so a stale value cannot pass
        sdata_o <= ~sdata_o;
        tick(8);
    endtask
endmodule

// file: verification/adcoi_config_top_tb.sv
// self-checking bench for the output interface configuration bank
module adcoi_config_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, reset_n, override, strobe, dbl_mode; // driven inputs
    logic [15:0] pat_one;                                    // first user pattern
    logic [7:0]  pat_two_hi;                                 // second pattern high byte
    wire         sen_n, sclk, sdata, sdout, sdout_oe;        // serial port
    wire  [15:0] pat_two, test_pat;                          // pattern outputs
    wire         clk_sh, clk_pc, data_dbl, frame_dbl;        // drive strength
    wire         off_a, off_b, rate, dly_bad;                // disables, mode, flag
    wire  [4:0]  dly;                                        // effective delay
    int          miscompares, check_count, cycles;
    logic        oe_seen;                                    // sdout driven in a read
    logic [4:0]  codes [8] = '{5'h05, 5'h07, 5'h00, 5'h0d, 5'h0e, 5'h0b, 5'h14, 5'h10};

    adcoi_config_top i_adcoi_config_top (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .spi_sen_n_i(sen_n), .spi_sclk_i(sclk),
        .spi_sdata_i(sdata), .spi_sdout_o(sdout), .spi_sdout_oe_o(sdout_oe),
        .pin_control_override_i(override), .sample_strobe_i(strobe),
        .double_mode_i(dbl_mode), .pattern_one_i(pat_one), .pattern_two_high_i(pat_two_hi),
        .second_user_pattern_o(pat_two), .test_pattern_o(test_pat),
        .shared_clk_dbl_o(clk_sh), .per_channel_clk_dbl_o(clk_pc), .data_dbl_o(data_dbl),
        .frame_clk_dbl_o(frame_dbl), .chan_a_output_off_o(off_a),
        .chan_b_output_off_o(off_b), .output_rate_mode_o(rate), .ddr_clk_delay_o(dly),
        .ddr_delay_illegal_o(dly_bad)
    );
    adcoi_host_model i_adcoi_host_model (
        .sys_clk_i(sys_clk), .sen_n_o(sen_n), .sclk_o(sclk), .sdata_o(sdata),
        .sdout_i(sdout)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // hang guard: a full run needs well under 10000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    always @(posedge sys_clk) if (sdout_oe === 1'b1) oe_seen <= 1'b1;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        i_adcoi_host_model.xfer(1'b0, a, d, unused);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        oe_seen = 1'b0;
        i_adcoi_host_model.xfer(1'b1, a, 8'h00, d);
        chk("register read", {8'h00, exp}, {8'h00, d});
        chk("sdout drive", 16'h0001, {15'h0000, oe_seen});
        chk("sdout release", 16'h0000, {15'h0000, sdout_oe});
    endtask

    // order: shared clk, per-channel clk, frame, data, chan a off, chan b off, ddr
    task automatic outs(input logic [6:0] e);
        chk("drive outputs", {9'h000, e}, {9'h000, clk_sh, clk_pc, frame_dbl, data_dbl,
            off_a, off_b, rate});
    endtask

    // one sample strobe, then the pattern after it has settled
    task automatic sample(input logic [15:0] exp);
        strobe <= 1'b1;
        @(posedge sys_clk);
        strobe <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("test pattern", exp, test_pat);
    endtask

    initial begin
        reset_n = 1'b0;
        override = 1'b0;
        strobe = 1'b0;
        dbl_mode = 1'b0;
        pat_one = 16'h0000;
        pat_two_hi = 8'h3c;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int a = 8'h13; a <= 8'h17; a++) rdc(a[6:0], 8'h00);
        outs(7'b0000000);
        wr(7'h13, 8'ha5);
        rdc(7'h13, 8'ha5);
        chk("second pattern", 16'h3ca5, pat_two);
        wr(7'h14, 8'h0f);
        rdc(7'h14, 8'h0f);
        outs(7'b0011110);
        wr(7'h17, 8'h80);
        outs(7'b0111110);
        wr(7'h15, 8'h01);
        rdc(7'h15, 8'h01);
        outs(7'b1001111);
        wr(7'h14, 8'h0a);
        outs(7'b1000101);
        wr(7'h14, 8'h05);
        outs(7'b0001011);
        wr(7'h17, 8'h00);
        wr(7'h14, 8'h08);
        outs(7'b0000001);
        // every listed delay code, first without and then with override
        foreach (codes[i]) begin
            override <= 1'b0;
            wr(7'h16, {2'b00, codes[i], 1'b0});
            chk("delay held", 16'h0000, {11'h000, dly});
            override <= 1'b1;
            repeat (3) @(posedge sys_clk);
            chk("delay applied", {11'h000, codes[i]}, {11'h000, dly});
            chk("illegal flag", 16'h0000, {15'h0000, dly_bad});
        end
        rdc(7'h16, 8'h20);
        wr(7'h16, 8'h02);
        chk("illegal delay", 16'h0000, {11'h000, dly});
        chk("illegal flag", 16'h0001, {15'h0000, dly_bad});
        rdc(7'h20, 8'h00);
        // double pattern: one, two, one on successive samples
        pat_one <= 16'h1234;
        dbl_mode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sample(16'h1234);
        sample(16'h3ca5);
        sample(16'h1234);
        tally_and_finish();
    end
endmodule
